// [src/tcdl_defines.vh]
// constants shared by the twelve-channel serial code loader
`ifndef TCDL_DEFINES_VH
`define TCDL_DEFINES_VH

// ----------------------------------------------------------------
// word format
// ----------------------------------------------------------------
`define TCDL_WORD_BITS      12
`define TCDL_ADDR_MSB       11
`define TCDL_ADDR_LSB       8
`define TCDL_CODE_MSB       7
`define TCDL_CODE_LSB       0
`define TCDL_CNT_BITS       4

// ----------------------------------------------------------------
// channels
// ----------------------------------------------------------------
`define TCDL_NUM_CH         12
`define TCDL_LAST_ADDR      4'hB
`define TCDL_MIDSCALE       8'h80
`define TCDL_CODE_SPAN      256

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCDL_CLK_PERIOD_NS      10
`define TCDL_SCLK_MIN_PERIOD_NS 30
`define TCDL_SCLK_MIN_PERIOD_CYC \
    ((`TCDL_SCLK_MIN_PERIOD_NS + `TCDL_CLK_PERIOD_NS - 1) / `TCDL_CLK_PERIOD_NS)

`endif

// [src/tcdl_sync.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module tcdl_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire rst_val_i,
    input  wire async_i,
    output reg  level_o
);

    reg meta_reg;
    reg s2_reg;
    reg s3_reg;

    // ----------------------------------------------------------------
    // sampling chain
    // ----------------------------------------------------------------
    // meta_reg feeds only s2_reg; filtering looks at stages two and three
    always @(posedge clk_i) begin
        meta_reg <= async_i;
        s2_reg   <= meta_reg;
        s3_reg   <= s2_reg;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= rst_val_i;
        end else if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end

endmodule

// [src/tcdl_shifter.v]
// twelve-bit serial input register with saturating bit count
`timescale 1ns/1ps
`include "tcdl_defines.vh"

module tcdl_shifter (
    input  wire                        clk_i,
    input  wire                        rst_i,
    input  wire                        clear_i,
    input  wire                        shift_i,
    input  wire                        bit_i,
    output wire [`TCDL_WORD_BITS-1:0]  word_next_o,
    output wire                        full_next_o
);

    reg  [`TCDL_WORD_BITS-1:0] word_reg;
    reg  [`TCDL_CNT_BITS-1:0]  count_reg;
    wire [`TCDL_CNT_BITS-1:0]  count_next;

    // older bits fall off the top, so only the last twelve survive
    assign word_next_o = shift_i ? {word_reg[`TCDL_WORD_BITS-2:0], bit_i} : word_reg;
    assign count_next  = clear_i ? {`TCDL_CNT_BITS{1'b0}} :
                         (shift_i && count_reg != `TCDL_WORD_BITS) ?
                         count_reg + 4'h1 : count_reg;
    assign full_next_o = (count_next == `TCDL_WORD_BITS);

    always @(posedge clk_i) begin
        if (rst_i) begin
            word_reg  <= {`TCDL_WORD_BITS{1'b0}};
            count_reg <= {`TCDL_CNT_BITS{1'b0}};
        end else begin
            word_reg  <= word_next_o;
            count_reg <= count_next;
        end
    end

endmodule

// [src/tcdl_loader.v]
// twelve-channel serial code loader: link sampling, decode and code registers
`timescale 1ns/1ps
`include "tcdl_defines.vh"

// Notes on behaviour
// R1: one update is carried by a twelve-bit word shifted in while select is low.
// R2: four address bits first, then eight code bits, each most significant first.
// R3: channel number equals binary address plus one, channels one to twelve.
// R4: the low eight bits of the word become the selected channel code.
// R5: select low: each serial clock rise shifts one data bit; high: no effect.
// R6: host holds serial clock high while raising select.
// R7: at select rise only the last twelve shifted bits are kept.
// R8: select rise enables the decoder, loading exactly one channel register.
// R9: channels update one per word, in any order.
// R10: serial load path accepts serial clock rates up to 33 MHz; here two-cycle half periods limit it to 25 MHz.
// R11: active-low preset sets every channel code to midscale 128.
// R12: preset acts independent of the serial clock and loads 80 hex.
// R13: while power-down is asserted all channel codes are retained; here preset still loads midscale during power-down.
// R14: during power-down all twelve channel outputs are open circuit.
// R15: on power-down release each output returns to its retained code.
// R16: output level is code over 256 of reference span plus low reference.
// R17: address values 1100 to 1111 leave every channel code unchanged.
module tcdl_loader (
    input  wire                        CLK_I,
    input  wire                        RESET_I,
    input  wire                        SCLK_I,
    input  wire                        SELECT_N_I,
    input  wire                        SERIAL_DATA_IN_I,
    input  wire                        MIDSCALE_PRESET_N_I,
    input  wire                        POWER_DOWN_N_I,
    output wire [8*`TCDL_NUM_CH-1:0]   CHANNEL_CODE_O,
    output reg  [`TCDL_NUM_CH-1:0]     CHANNEL_OE_N_O,
    output reg                         UPDATE_O,
    output reg  [3:0]                  UPDATE_ADDR_O,
    output reg                         WORD_DROPPED_O,
    output reg                         BUSY_O
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // address to one-hot channel enable; out-of-range gives all zero
    function [`TCDL_NUM_CH-1:0] addr_onehot;
        input [3:0] addr;
        integer k;
        begin
            addr_onehot = {`TCDL_NUM_CH{1'b0}};
            for (k = 0; k < `TCDL_NUM_CH; k = k + 1) begin
                if (addr == k[3:0]) begin
                    addr_onehot[k] = 1'b1;
                end
            end
        end
    endfunction

    function addr_valid;
        input [3:0] addr;
        begin
            addr_valid = (addr <= `TCDL_LAST_ADDR);
        end
    endfunction

    // level tests: the rise test serves the link clock and the select line, the fall test the select line only
    function level_rose;
        input cur;
        input prev;
        begin
            level_rose = cur & ~prev;
        end
    endfunction

    function level_fell;
        input cur;
        input prev;
        begin
            level_fell = ~cur & prev;
        end
    endfunction

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    // the link clock is only sampled, so its highest usable rate is bounded
    // by this clock: each half period must last at least two cycles here [R10]
    wire sclk_lvl;
    wire sel_n_lvl;
    wire sdi_lvl;
    wire preset_n_lvl;
    wire pwr_n_lvl;

    tcdl_sync u_sync_sclk (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .rst_val_i (1'b1),
        .async_i   (SCLK_I),
        .level_o   (sclk_lvl)
    );

    tcdl_sync u_sync_sel (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .rst_val_i (1'b1),
        .async_i   (SELECT_N_I),
        .level_o   (sel_n_lvl)
    );

    tcdl_sync u_sync_sdi (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .rst_val_i (1'b0),
        .async_i   (SERIAL_DATA_IN_I),
        .level_o   (sdi_lvl)
    );

    tcdl_sync u_sync_preset (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .rst_val_i (1'b1),
        .async_i   (MIDSCALE_PRESET_N_I),
        .level_o   (preset_n_lvl)
    );

    tcdl_sync u_sync_pwr (
        .clk_i     (CLK_I),
        .rst_i     (RESET_I),
        .rst_val_i (1'b1),
        .async_i   (POWER_DOWN_N_I),
        .level_o   (pwr_n_lvl)
    );

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    // synchronisers and previous-level flops both reset to the idle levels
    // so that release of reset never fakes a clock or select edge
    localparam FR_UNARMED = 2'b00;
    localparam FR_IDLE    = 2'b01;
    localparam FR_ACTIVE  = 2'b10;

    reg       sclk_prev_reg;
    reg       sel_n_prev_reg;
    reg [1:0] frame_reg;
    reg [1:0] frame_next;

    wire sel_armed;
    wire sclk_rise;
    wire sel_rise;
    wire sel_fall;
    wire sel_active;

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            sclk_prev_reg  <= 1'b1;
            sel_n_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg  <= sclk_lvl;
            sel_n_prev_reg <= sel_n_lvl;
        end
    end

    // a frame counts once select reads high on two samples, which the reset values of both flops already give, so this arms on the first cycle after reset;
    // a host caught mid-frame at reset release then shows a select fall, and its short word is dropped for want of twelve bits
    always @* begin
        frame_next = frame_reg;
        case (frame_reg)
            FR_UNARMED: begin
                if (sel_n_lvl && sel_n_prev_reg) begin
                    frame_next = FR_IDLE;
                end
            end
            FR_IDLE: begin
                if (!sel_n_lvl) begin
                    frame_next = FR_ACTIVE;
                end
            end
            FR_ACTIVE: begin
                if (sel_n_lvl) begin
                    frame_next = FR_IDLE;
                end
            end
            default: begin
                frame_next = FR_UNARMED;
            end
        endcase
    end

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            frame_reg <= FR_UNARMED;
        end else begin
            frame_reg <= frame_next;
        end
    end

    assign sel_armed  = (frame_reg != FR_UNARMED);
    assign sclk_rise  = level_rose(sclk_lvl, sclk_prev_reg);
    assign sel_fall   = sel_armed & level_fell(sel_n_lvl, sel_n_prev_reg);
    assign sel_rise   = sel_armed & level_rose(sel_n_lvl, sel_n_prev_reg);
    assign sel_active = (frame_reg == FR_ACTIVE);

    // ----------------------------------------------------------------
    // serial input register
    // ----------------------------------------------------------------
    // a clock rise in the cycle select is seen rising still counts, since
    // the previous select level was low; with the host keeping the clock
    // high at that moment this case does not arise in practice [R6]
    wire                       do_shift;
    wire [`TCDL_WORD_BITS-1:0] word_next;
    wire                       full_next;

    assign do_shift = sclk_rise & sel_active; // [R5]

    tcdl_shifter u_shifter (
        .clk_i       (CLK_I),
        .rst_i       (RESET_I),
        .clear_i     (sel_fall),
        .shift_i     (do_shift),
        .bit_i       (sdi_lvl),
        .word_next_o (word_next),
        .full_next_o (full_next)
    );

    // ----------------------------------------------------------------
    // word decode
    // ----------------------------------------------------------------
    wire [3:0]              word_addr;
    wire [7:0]              word_code;
    wire [`TCDL_NUM_CH-1:0] load_en;
    wire                    word_ok;

    // first four bits received sit at the top, the code at the bottom
    assign word_addr = word_next[`TCDL_ADDR_MSB:`TCDL_ADDR_LSB];  // [R2] [R7]
    assign word_code = word_next[`TCDL_CODE_MSB:`TCDL_CODE_LSB];  // [R4]

    // a short frame carries no complete word and is dropped
    assign word_ok = sel_rise & full_next & addr_valid(word_addr) // [R1] [R17]
                     & pwr_n_lvl & preset_n_lvl;                  // [R13]

    // binary address k drives channel k+1, stored at array index k
    assign load_en = word_ok ? addr_onehot(word_addr) :           // [R3] [R8]
                     {`TCDL_NUM_CH{1'b0}};

    // ----------------------------------------------------------------
    // channel code registers
    // ----------------------------------------------------------------
    // preset is level sensitive and needs no serial clock; it outranks a
    // word landing in the same cycle and also acts during power-down
    reg [7:0] code_reg [0:`TCDL_NUM_CH-1];

    genvar g;
    generate
        for (g = 0; g < `TCDL_NUM_CH; g = g + 1) begin : g_ch
            always @(posedge CLK_I) begin
                if (RESET_I) begin
                    code_reg[g] <= `TCDL_MIDSCALE;
                end else if (!preset_n_lvl) begin
                    code_reg[g] <= `TCDL_MIDSCALE;            // [R11] [R12]
                end else if (load_en[g]) begin
                    code_reg[g] <= word_code;                 // [R4] [R9]
                end
            end

            // the analog stage scales each code by span/256 over the low
            // reference; this logic delivers only the code [R16]
            assign CHANNEL_CODE_O[8*g+7:8*g] = code_reg[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // output drive control
    // ----------------------------------------------------------------
    // codes are never touched by power-down, so release simply re-enables
    // the drivers onto the retained levels
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            CHANNEL_OE_N_O <= {`TCDL_NUM_CH{1'b0}};
        end else if (!pwr_n_lvl) begin
            CHANNEL_OE_N_O <= {`TCDL_NUM_CH{1'b1}};           // [R14]
        end else begin
            CHANNEL_OE_N_O <= {`TCDL_NUM_CH{1'b0}};           // [R15]
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    reg       update_next;
    reg [3:0] update_addr_next;
    reg       dropped_next;

    always @* begin
        update_next      = 1'b0;
        update_addr_next = UPDATE_ADDR_O;
        dropped_next     = 1'b0;
        if (word_ok) begin
            update_next      = 1'b1;
            update_addr_next = word_addr;
        end else if (sel_rise) begin
            dropped_next     = 1'b1;
        end
    end

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            UPDATE_O       <= 1'b0;
            UPDATE_ADDR_O  <= 4'h0;
            WORD_DROPPED_O <= 1'b0;
            BUSY_O         <= 1'b0;
        end else begin
            UPDATE_O       <= update_next;
            UPDATE_ADDR_O  <= update_addr_next;
            WORD_DROPPED_O <= dropped_next;
            BUSY_O         <= (frame_next == FR_ACTIVE);
        end
    end

endmodule

// [tb/tcdl_loader_asserts.sv]
// port assertions for the twelve-channel code loader
`timescale 1ns/1ps
`include "tcdl_defines.vh"
module tcdl_loader_asserts (
    input wire                      CLK_I,
    input wire                      RESET_I,
    input wire                      SCLK_I,
    input wire                      SELECT_N_I,
    input wire                      SERIAL_DATA_IN_I,
    input wire                      MIDSCALE_PRESET_N_I,
    input wire                      POWER_DOWN_N_I,
    input wire [8*`TCDL_NUM_CH-1:0] CHANNEL_CODE_O,
    input wire [`TCDL_NUM_CH-1:0]   CHANNEL_OE_N_O,
    input wire                      UPDATE_O,
    input wire [3:0]                UPDATE_ADDR_O,
    input wire                      WORD_DROPPED_O,
    input wire                      BUSY_O
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    a_upd_one_pulse: assert property (UPDATE_O |=> !UPDATE_O)
        else $error("update pulse longer than one cycle");
    a_drop_one_pulse: assert property (WORD_DROPPED_O |=> !WORD_DROPPED_O)
        else $error("drop pulse longer than one cycle");
    a_upd_not_drop: assert property (!(UPDATE_O && WORD_DROPPED_O))
        else $error("update and drop together");
    a_upd_addr_range: assert property (UPDATE_O |-> UPDATE_ADDR_O <= 4'hB)
        else $error("update for unmapped address");
    a_upd_after_sel: assert property (UPDATE_O |-> SELECT_N_I && $past(SELECT_N_I, 3))
        else $error("update without select rise");
    a_preset_mid: assert property ((!MIDSCALE_PRESET_N_I) [*8] |-> CHANNEL_CODE_O == {12{8'h80}})
        else $error("preset did not load midscale");
    a_pd_open: assert property ((!POWER_DOWN_N_I) [*8] |-> CHANNEL_OE_N_O == 12'hFFF)
        else $error("outputs driven in power-down");
    a_pd_drive: assert property (POWER_DOWN_N_I [*8] |-> CHANNEL_OE_N_O == 12'h000)
        else $error("outputs not driven after power-down");
    a_pd_retain: assert property ((!POWER_DOWN_N_I && MIDSCALE_PRESET_N_I) [*8] |=> $stable(CHANNEL_CODE_O))
        else $error("codes changed in power-down");
    a_code_cause: assert property (MIDSCALE_PRESET_N_I [*8] ##0 $changed(CHANNEL_CODE_O) |-> UPDATE_O)
        else $error("code changed without update");
    a_sel_idle: assert property (SELECT_N_I [*8] |-> !BUSY_O)
        else $error("busy with select high");
    a_busy_in_frame: assert property ((!SELECT_N_I) [*8] |-> BUSY_O)
        else $error("not busy with select low");
endmodule
bind tcdl_loader tcdl_loader_asserts i_tcdl_loader_asserts (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .SCLK_I(SCLK_I), .SELECT_N_I(SELECT_N_I),
    .SERIAL_DATA_IN_I(SERIAL_DATA_IN_I), .MIDSCALE_PRESET_N_I(MIDSCALE_PRESET_N_I),
    .POWER_DOWN_N_I(POWER_DOWN_N_I), .CHANNEL_CODE_O(CHANNEL_CODE_O),
    .CHANNEL_OE_N_O(CHANNEL_OE_N_O), .UPDATE_O(UPDATE_O), .UPDATE_ADDR_O(UPDATE_ADDR_O),
    .WORD_DROPPED_O(WORD_DROPPED_O), .BUSY_O(BUSY_O));

// [tb/tcdl_host_model.sv]
// host serial master model driving the three-wire link
`timescale 1ns/1ps
module tcdl_host_model (
    input  wire  clk_i,
    output logic sclk_o,
    output logic sel_n_o,
    output logic sdi_o
);
    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    initial begin
        sclk_o  = 1'b1;
        sel_n_o = 1'b1;
        sdi_o   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // four-cycle half period gives the 80 ns link clock
    task automatic send(input int nbits, input logic [15:0] w);
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        tick(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_o <= 1'b0;
            sdi_o  <= w[i];
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
        end
        sel_n_o <= 1'b1;
        tick(1);
        // released data line shows the inverse, never a stale bit
        sdi_o <= ~sdi_o;
        tick(8);
    endtask
endmodule

// [tb/tcdl_loader_bench.sv]
// self-checking bench for the twelve-channel code loader
`timescale 1ns/1ps
module tcdl_loader_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        preset_n = 1'b1;
    logic        pd_n = 1'b1;
    wire         sclk, sel_n, serial_data_in, upd, dropped, busy;
    wire  [95:0] codes;
    wire  [11:0] oe_n;
    wire  [3:0]  upd_addr;
    logic [12:0] exp_q[$];
    logic [7:0]  mdl[12];
    logic [12:0] got_res;
    int          err_total = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // ----------------------------------------------------------------
    // instances, clock, watchdog
    // ----------------------------------------------------------------
    tcdl_host_model i_tcdl_host_model (.clk_i(clk), .sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(serial_data_in));
    tcdl_loader i_tcdl_loader (.CLK_I(clk), .RESET_I(rst), .SCLK_I(sclk), .SELECT_N_I(sel_n),
        .SERIAL_DATA_IN_I(serial_data_in), .MIDSCALE_PRESET_N_I(preset_n), .POWER_DOWN_N_I(pd_n),
        .CHANNEL_CODE_O(codes), .CHANNEL_OE_N_O(oe_n), .UPDATE_O(upd),
        .UPDATE_ADDR_O(upd_addr), .WORD_DROPPED_O(dropped), .BUSY_O(busy));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp_res(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_vec(input logic [95:0] got, input logic [95:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [95:0] mvec();
        for (int k = 0; k < 12; k++) mvec[8*k +: 8] = mdl[k];
    endfunction
    // expected outcome noted before the frame goes out
    task automatic word(input int n, input logic [15:0] w, input logic drop);
        if (!drop) mdl[w[11:8]] = w[7:0];
        exp_q.push_back(drop ? 13'h1000 : {1'b0, w[11:0]});
        i_tcdl_host_model.send(n, w);
    endtask
    always @(negedge clk) begin
        if (!rst && (upd === 1'b1 || dropped === 1'b1)) begin
            got_res = dropped ? 13'h1000 : {1'b0, upd_addr, codes[upd_addr*8 +: 8]};
            if (exp_q.size() == 0) cmp_res(13'h1FFF, 13'h0000);
            else cmp_res(got_res, exp_q.pop_front());
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h6213));
        for (int k = 0; k < 12; k++) mdl[k] = 8'h80;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int k = 11; k >= 0; k--) word(12, {4'h0, k[3:0], 8'($urandom)}, 1'b0);
        @(negedge clk) cmp_vec(codes, mvec());
        word(16, {4'hA, 4'h3, 8'h5A}, 1'b0);
        for (int a = 12; a < 16; a++) word(12, {4'h0, a[3:0], 8'hFF}, 1'b1);
        word(11, 16'h02C5, 1'b1);
        @(negedge clk) cmp_vec(codes, mvec());
        @(posedge clk) pd_n <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk) cmp_vec({84'h0, oe_n}, {84'h0, 12'hFFF});
        word(12, {4'h0, 4'h4, 8'($urandom)}, 1'b1);
        @(negedge clk) cmp_vec(codes, mvec());
        @(posedge clk) pd_n <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) cmp_vec({84'h0, oe_n}, 96'h0);
        cmp_vec(codes, mvec());
        @(posedge clk) preset_n <= 1'b0;
        repeat (10) @(posedge clk);
        for (int k = 0; k < 12; k++) mdl[k] = 8'h80;
        @(negedge clk) cmp_vec(codes, mvec());
        @(posedge clk) preset_n <= 1'b1;
        repeat (8) @(posedge clk);
        word(12, {4'h0, 4'h5, 8'($urandom)}, 1'b0);
        @(negedge clk) cmp_vec(codes, mvec());
        cmp_res(13'(exp_q.size()), 13'h0000);
        conclude();
    end
endmodule
